// >>> core/ssr_host.sv
`timescale 1ns/1ps

// Notes on behaviour
// RQ1 - STORE needs six reads: 0E38,31C7,03E0,3C1F,303F,0FC0 in order.
// RQ2 - RECALL needs same first five reads, then 0C63.
// RQ3 - First five sequence reads return ordinary stored bytes.
// RQ4 - Any other access mid-sequence aborts; no store or recall.
// RQ5 - Sequence steps use chip-enable-controlled reads, never writes.
// RQ6 - Write enable stays high through all six sequence cycles.
// RQ7 - Sequence valid whether or not output enable is low.
// RQ8 - Only the low 14 address bits select command steps.
// RQ9 - Device bus is disabled once a STORE triggers.
// RQ10 - Bus usable again after store duration elapses.
// RQ11 - STORE erases nonvolatile array then programs it from SRAM.
// RQ12 - RECALL clears SRAM then loads it from nonvolatile array.
// RQ13 - RECALL leaves nonvolatile data intact; unlimited recalls allowed.
// RQ14 - Bus usable again only after recall duration from start.
// RQ15 - Below supply switch threshold, stores and writes are blocked.
// RQ16 - Software STORE proceeds even without prior write.
// RQ17 - Read: chip enable, output enable low, write enable high; write: both low.
// RQ18 - Device restarts matcher on mismatch; step one address reseeds it.
module ssr_host
    import ssr_pkg::*;
#(
    parameter int ADDR_WIDTH    = ADDR_W,
    parameter int DATA_WIDTH    = DATA_W,
    parameter int STORE_WAIT    = STORE_CYCLES,
    parameter int RECALL_WAIT   = RECALL_CYCLES
)
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rstn,
    // User request
    input  wire logic                  req_valid,
    output logic                       req_ready,
    input  wire ssr_op_type            req_op,
    input  wire logic [ADDR_WIDTH-1:0] req_addr,
    input  wire logic [DATA_WIDTH-1:0] req_wdata,
    input  wire logic                  supply_low,
    // User answer
    output logic                       rsp_valid,
    output logic [DATA_WIDTH-1:0]      rsp_rdata,
    output logic                       rsp_refused,
    // Memory bus
    output logic [ADDR_WIDTH-1:0]      address_lines,
    input  wire logic [DATA_WIDTH-1:0] data_lines_in,
    output logic [DATA_WIDTH-1:0]      data_lines_out,
    output logic                       data_lines_oe,
    output logic                       chip_en_n,
    output logic                       write_en_n,
    output logic                       out_en_n
);

    typedef enum logic [2:0]
    {
        SSR_IDLE   = 3'b000,
        SSR_ACCESS = 3'b001,
        SSR_SEQ    = 3'b010,
        SSR_WAIT   = 3'b011,
        SSR_DONE   = 3'b100
    } ssr_state_type;

    ssr_state_type         state;
    ssr_state_type         next_state;
    ssr_op_type            op;
    logic [2:0]            step;
    logic [WAIT_W-1:0]     wait_count;
    logic                  cyc_start;
    logic                  cyc_strobe;
    logic                  cyc_sample;
    logic                  cyc_busy;
    logic                  cyc_done;
    logic                  cyc_busy_q;
    logic [MATCH_W-1:0]    seq_addr;
    logic                  is_write;
    logic                  is_cmd;
    logic                  refuse;
    logic                  accept;

    ////////////////////////////////////////////////////////////////////////////
    // Request decode
    assign is_write  = (req_op == SSR_OP_WRITE);
    assign is_cmd    = (req_op == SSR_OP_STORE) || (req_op == SSR_OP_RECALL);
    assign refuse    = supply_low && (is_write || req_op == SSR_OP_STORE);  // [RQ15]
    assign req_ready = (state == SSR_IDLE);
    assign accept    = req_valid && req_ready;
    assign cyc_done  = cyc_busy_q && !cyc_busy;

    // Address of the current sequence step
    always_comb
    begin
        unique case (step)
            3'd0:    seq_addr = SEQ_ADDR_1;                         // [RQ1] [RQ2]
            3'd1:    seq_addr = SEQ_ADDR_2;
            3'd2:    seq_addr = SEQ_ADDR_3;
            3'd3:    seq_addr = SEQ_ADDR_4;
            3'd4:    seq_addr = SEQ_ADDR_5;
            default: seq_addr = (op == SSR_OP_STORE) ? SEQ_ADDR_STORE : SEQ_ADDR_RECALL;
        endcase
    end

    // Next state
    always_comb
    begin
        next_state = state;
        unique case (state)
            SSR_IDLE:
                if (accept && !refuse)
                    next_state = is_cmd ? SSR_SEQ : SSR_ACCESS;
                else if (accept)
                    next_state = SSR_DONE;
            SSR_ACCESS:
                if (cyc_done)
                    next_state = SSR_DONE;
            SSR_SEQ:
                if (cyc_done && step == 3'(SEQ_STEPS - 1))
                    next_state = SSR_WAIT;                          // [RQ9]
            SSR_WAIT:
                if (wait_count == '0)
                    next_state = SSR_DONE;                          // [RQ10] [RQ14]
            SSR_DONE:
                next_state = SSR_IDLE;
            default:
                next_state = SSR_IDLE;
        endcase
    end

    // Launch a bus cycle on entry and between back-to-back sequence steps [RQ4]
    assign cyc_start = (state == SSR_ACCESS || state == SSR_SEQ) && !cyc_busy && !cyc_busy_q;

    ssr_cycle u_cycle
    (
        .clk    (clk),
        .rstn   (rstn),
        .start  (cyc_start),
        .strobe (cyc_strobe),
        .sample (cyc_sample),
        .busy   (cyc_busy)
    );

    ////////////////////////////////////////////////////////////////////////////
    // State and request capture
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state      <= SSR_IDLE;
            op         <= SSR_OP_READ;
            cyc_busy_q <= 1'b0;
        end
        else
        begin
            state      <= next_state;
            cyc_busy_q <= cyc_busy;
            if (accept)
                op <= req_op;
        end
    end

    // Step counter and post-command wait
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            step       <= 3'd0;
            wait_count <= '0;
        end
        else
        begin
            if (accept)
                step <= 3'd0;
            else if (state == SSR_SEQ && cyc_done)
                step <= step + 3'd1;
            if (state == SSR_SEQ)
                wait_count <= (op == SSR_OP_STORE) ? WAIT_W'(STORE_WAIT) : WAIT_W'(RECALL_WAIT);
            else if (state == SSR_WAIT && wait_count != '0)
                wait_count <= wait_count - 1'b1;                    // [RQ10] [RQ14]
        end
    end

    // Bus pins from flip-flops
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            address_lines  <= '0;
            data_lines_out <= '0;
            data_lines_oe  <= 1'b0;
            chip_en_n      <= 1'b1;
            write_en_n     <= 1'b1;
            out_en_n       <= 1'b1;
        end
        else
        begin
            if (accept)
            begin
                address_lines  <= req_addr;
                data_lines_out <= req_wdata;
            end
            else if (state == SSR_SEQ)
                address_lines <= ADDR_WIDTH'({1'b0, seq_addr});     // [RQ8]
            // Sequence steps strobe chip enable, write enable held high [RQ5] [RQ6] [RQ17]
            chip_en_n     <= !cyc_strobe;
            write_en_n    <= !(cyc_strobe && state == SSR_ACCESS && op == SSR_OP_WRITE);
            out_en_n      <= !(cyc_strobe && state == SSR_ACCESS && op == SSR_OP_READ);  // [RQ7]
            data_lines_oe <= cyc_busy && state == SSR_ACCESS && op == SSR_OP_WRITE;
        end
    end

    // Answer; sequence reads are not returned [RQ3]
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rsp_valid   <= 1'b0;
            rsp_rdata   <= '0;
            rsp_refused <= 1'b0;
        end
        else
        begin
            rsp_valid <= (next_state == SSR_DONE) && (state != SSR_DONE);
            if (accept)
                rsp_refused <= refuse;
            if (cyc_sample && state == SSR_ACCESS && op == SSR_OP_READ)
                rsp_rdata <= data_lines_in;
        end
    end

endmodule : ssr_host

// >>> inc/ssr_pkg.sv
package ssr_pkg;

    // Bus geometry
    localparam int ADDR_W     = 15;
    localparam int DATA_W     = 8;
    localparam int MATCH_W    = 14;

    // Command sequence addresses, low 14 bits only
    localparam logic [13:0] SEQ_ADDR_1      = 14'h0e38;
    localparam logic [13:0] SEQ_ADDR_2      = 14'h31c7;
    localparam logic [13:0] SEQ_ADDR_3      = 14'h03e0;
    localparam logic [13:0] SEQ_ADDR_4      = 14'h3c1f;
    localparam logic [13:0] SEQ_ADDR_5      = 14'h303f;
    localparam logic [13:0] SEQ_ADDR_STORE  = 14'h0fc0;
    localparam logic [13:0] SEQ_ADDR_RECALL = 14'h0c63;
    localparam int          SEQ_STEPS       = 6;

    // Timing
    localparam int CLK_PERIOD_NS       = 20;
    localparam int STORE_DURATION_US   = 10;
    localparam int RECALL_DURATION_US  = 20;
    localparam int STORE_CYCLES        = (STORE_DURATION_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECALL_CYCLES       = (RECALL_DURATION_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_CYCLES        = 3;
    localparam int STROBE_CYCLES       = 3;
    localparam int GAP_CYCLES          = 2;
    localparam int WAIT_W              = 20;

    // Host request kinds
    typedef enum logic [1:0]
    {
        SSR_OP_READ   = 2'b00,
        SSR_OP_WRITE  = 2'b01,
        SSR_OP_STORE  = 2'b10,
        SSR_OP_RECALL = 2'b11
    } ssr_op_type;

endpackage : ssr_pkg

// >>> core/ssr_cycle.sv
`timescale 1ns/1ps

// One chip-enable-controlled bus cycle: setup, strobe, gap
module ssr_cycle
    import ssr_pkg::*;
#(
    parameter int SETUP  = SETUP_CYCLES,
    parameter int STROBE = STROBE_CYCLES,
    parameter int GAP    = GAP_CYCLES
)
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // Control
    input  wire logic start,
    output logic      strobe,
    output logic      sample,
    output logic      busy
);

    localparam int TOTAL = SETUP + STROBE + GAP;

    logic [7:0] count;
    logic       running;

    ////////////////////////////////////////////////////////////////////////////
    // Phase decode
    assign busy   = running;
    assign strobe = running && (count >= 8'(SETUP)) && (count < 8'(SETUP + STROBE));
    assign sample = running && (count == 8'(SETUP + STROBE - 1));

    // Phase counter
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            count   <= 8'h00;
            running <= 1'b0;
        end
        else if (!running)
        begin
            running <= start;
            count   <= 8'h00;
        end
        else
        begin
            running <= (count != 8'(TOTAL - 1));
            count   <= count + 8'h01;
        end
    end

endmodule : ssr_cycle

// >>> tb/ssr_host_properties.sv
`timescale 1ns/1ps
// Pin protocol checks on the host
module ssr_host_properties
    import ssr_pkg::*;
(
    // Clock, reset and request
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        req_valid,
    input wire logic        req_ready,
    input wire ssr_op_type  req_op,
    input wire logic        supply_low,
    // Answer and bus
    input wire logic        rsp_valid,
    input wire logic        rsp_refused,
    input wire logic [14:0] address_lines,
    input wire logic        data_lines_oe,
    input wire logic        chip_en_n,
    input wire logic        write_en_n,
    input wire logic        out_en_n
);
    localparam logic [13:0] SQ [5] = '{SEQ_ADDR_1, SEQ_ADDR_2, SEQ_ADDR_3, SEQ_ADDR_4, SEQ_ADDR_5};
    ssr_op_type  op;
    logic        act;
    logic        ce_q;
    logic [2:0]  n;
    wire         take = req_valid && req_ready;
    wire         seq  = act && op[1];
    wire  [13:0] want = n < 3'h5 ? SQ[n] : (op[0] ? SEQ_ADDR_RECALL : SEQ_ADDR_STORE);
    // Running request and count of chip-enable falls
    always_ff @(posedge clk or negedge rstn)
        if (!rstn)
        begin
            act  <= 1'b0;
            op   <= SSR_OP_READ;
            ce_q <= 1'b1;
            n    <= 3'h0;
        end
        else
        begin
            act  <= take || (act && !rsp_valid);
            op   <= take ? req_op : op;
            ce_q <= chip_en_n;
            n    <= take ? 3'h0 : n + 3'(ce_q && !chip_en_n);
        end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_step;
        seq && $fell(chip_en_n);
    endsequence
    // Refusal answers in the cycle after the take, with no bus activity
    sequence s_refused;
        (rsp_valid && rsp_refused && chip_en_n) ##1 (chip_en_n && !rsp_valid);
    endsequence
    a_seq_order: assert property (s_step |-> address_lines[13:0] == want)
        else $error("sequence address out of order");
    a_seq_count: assert property (seq && rsp_valid && !rsp_refused |-> n == 3'h6)
        else $error("sequence not six cycles");
    a_seq_reads: assert property (seq |-> write_en_n && !data_lines_oe)
        else $error("write inside a sequence");
    a_read_cycle: assert property (!chip_en_n && !out_en_n |-> write_en_n)
        else $error("read overlaps write strobe");
    a_write_cycle: assert property (!chip_en_n && !write_en_n |-> out_en_n && data_lines_oe)
        else $error("write without data drive");
    a_low_refuse: assert property (take && supply_low && req_op[0] != req_op[1] |=> s_refused)
        else $error("refusal not prompt");
endmodule : ssr_host_properties
bind ssr_host ssr_host_properties u_chk (.clk, .rstn, .req_valid, .req_ready, .req_op, .supply_low,
    .rsp_valid, .rsp_refused, .address_lines, .data_lines_oe, .chip_en_n, .write_en_n, .out_en_n);

// >>> tb/ssr_sram_model.sv
`timescale 1ns/1ps
// Shadowed memory on the asynchronous bus
module ssr_sram_model
    import ssr_pkg::*;
#(
    parameter int STORE_NS  = 400,
    parameter int RECALL_NS = 400
)
(
    // Bus pins
    input  wire logic [14:0] addr,
    input  wire logic [7:0]  din,
    output logic [7:0]       dout,
    output logic             drive,
    input  wire logic        ce_n,
    input  wire logic        we_n,
    input  wire logic        oe_n,
    // Supply below switch threshold
    input  wire logic        supply_low
);
    localparam logic [13:0] SQ [5] = '{SEQ_ADDR_1, SEQ_ADDR_2, SEQ_ADDR_3, SEQ_ADDR_4, SEQ_ADDR_5};
    logic [7:0] mem [32768];
    logic [7:0] nv [32768];
    logic [2:0] step = 3'h0;
    logic       dis = 1'b0;
    logic       wr_seen = 1'b0;
    wire        hit6 = step === 3'h5 && we_n === 1'b1;
    // Output only while read-selected; else inverted garbage
    assign drive = !ce_n && !oe_n && we_n && !dis;
    assign dout  = drive ? mem[addr] : ~mem[addr];
    initial
        for (int i = 0; i < 32768; i++)
            {mem[i], nv[i]} = {8'(i), 8'(~i)};
    // Note a write strobe inside the cycle; immune to both strobes rising together
    always @(negedge ce_n or negedge we_n)
        wr_seen = (we_n === 1'b0);
    // Close each chip-enable-controlled cycle
    always @(posedge ce_n)
        if (wr_seen)
        begin
            step = 3'h0;
            if (!supply_low && !dis)
                mem[addr] = din;
        end
        else if (hit6 && addr[13:0] === SEQ_ADDR_STORE && !supply_low)
        begin
            dis = 1'b1;
            nv = '{default: 8'hff};
            nv = mem;
            #(STORE_NS) dis = 1'b0;
            step = 3'h0;
        end
        else if (hit6 && addr[13:0] === SEQ_ADDR_RECALL)
        begin
            dis = 1'b1;
            mem = '{default: 8'h00};
            mem = nv;
            #(RECALL_NS) dis = 1'b0;
            step = 3'h0;
        end
        else
            step = (step < 3'h5 && addr[13:0] === SQ[step]) ? step + 3'h1 : 3'(addr[13:0] === SEQ_ADDR_1);
endmodule : ssr_sram_model

// >>> tb/sw_store_recall_sequencer_tb.sv
`timescale 1ns/1ps
// Host sequencer against the memory model
module sw_store_recall_sequencer_tb
    import ssr_pkg::*;
;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        req_valid = 1'b0;
    logic        supply_low = 1'b0;
    ssr_op_type  req_op = SSR_OP_READ;
    logic [14:0] req_addr = 15'h0000;
    logic [7:0]  req_wdata = 8'h00;
    logic        req_ready, rsp_valid, rsp_refused, oe, ce_n, we_n, oe_n;
    logic [14:0] addr;
    logic [7:0]  rsp_rdata, wdat, dout, dq;
    logic [9:0]  exp_q [$];
    logic [9:0]  e;
    logic [14:0] adr [4];
    logic [7:0]  sh [logic [14:0]];
    logic [7:0]  nv [logic [14:0]];
    int          errors = 0;
    int          checked = 0;
    int          cyc = 0;
    // Clock and the shared data wire
    always #10 clk = ~clk;
    assign dq = oe ? wdat : dout;
    ssr_host #(.STORE_WAIT(20), .RECALL_WAIT(20)) u_dut (.clk, .rstn, .req_valid, .req_ready, .req_op,
        .req_addr, .req_wdata, .supply_low, .rsp_valid, .rsp_rdata, .rsp_refused, .address_lines(addr),
        .data_lines_in(dq), .data_lines_out(wdat), .data_lines_oe(oe), .chip_en_n(ce_n), .write_en_n(we_n),
        .out_en_n(oe_n));
    ssr_sram_model #(.STORE_NS(400), .RECALL_NS(400)) u_mem (.addr, .din(dq), .dout, .drive(), .ce_n,
        .we_n, .oe_n, .supply_low);
    task automatic fail(string m);
        errors++;
        $display("mismatch at %0t: %s", $time, m);
    endtask : fail
    task automatic cmp_ref(logic got, logic exp);
        checked++;
        if (got !== exp) fail("refusal flag");
    endtask : cmp_ref
    task automatic cmp_data(logic [7:0] got, logic [7:0] exp);
        checked++;
        if (got !== exp) fail("read data");
    endtask : cmp_data
    // Issue one request, note its answer, wait for it
    task automatic op(ssr_op_type o, logic [14:0] a, logic [7:0] d, logic r);
        exp_q.push_back({r, o == SSR_OP_READ, sh.exists(a) ? sh[a] : 8'h00});
        if (o == SSR_OP_WRITE && !r) sh[a] = d;
        @(negedge clk);
        while (req_ready !== 1'b1) @(negedge clk);
        req_valid = 1'b1;
        req_op    = o;
        req_addr  = a;
        req_wdata = d;
        @(negedge clk);
        req_valid = 1'b0;
        while (exp_q.size() != 0) @(negedge clk);
    endtask : op
    task automatic wr_all(logic r);
        foreach (adr[i]) op(SSR_OP_WRITE, adr[i], 8'($urandom()), r);
    endtask : wr_all
    task automatic rd_all();
        foreach (adr[i]) op(SSR_OP_READ, adr[i], 8'h00, 1'b0);
    endtask : rd_all
    task automatic final_report();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report
    // Compare each answer with the oldest note
    always @(negedge clk)
        if (rsp_valid === 1'b1)
        begin
            if (exp_q.size() == 0)
                fail("unexpected answer");
            else
            begin
                e = exp_q.pop_front();
                cmp_ref(rsp_refused, e[9]);
                if (e[8]) cmp_data(rsp_rdata, e[7:0]);
            end
        end
    // Cut a hang short
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            final_report();
        end
    end
    // Main sequence
    initial
    begin
        void'($urandom(88596));
        foreach (adr[i]) adr[i] = 15'($urandom());
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        wr_all(1'b0);
        rd_all();
        $display("test read write done");
        op(SSR_OP_STORE, 15'h0000, 8'h00, 1'b0);
        nv = sh;
        wr_all(1'b0);
        rd_all();
        op(SSR_OP_RECALL, 15'h0000, 8'h00, 1'b0);
        sh = nv;
        rd_all();
        op(SSR_OP_RECALL, 15'h0000, 8'h00, 1'b0);
        rd_all();
        $display("test store recall done");
        op(SSR_OP_STORE, 15'h0000, 8'h00, 1'b0);
        supply_low = 1'b1;
        wr_all(1'b1);
        op(SSR_OP_STORE, 15'h0000, 8'h00, 1'b1);
        rd_all();
        supply_low = 1'b0;
        wr_all(1'b0);
        op(SSR_OP_RECALL, 15'h0000, 8'h00, 1'b0);
        sh = nv;
        rd_all();
        $display("test protect done");
        final_report();
    end
endmodule : sw_store_recall_sequencer_tb
